// [core/intc_pkg.sv]
// Purpose: Constants and types for the interrupt command/status block
// Assumes: 32-bit AHB-Lite data, one word per register
// Notes:   Offsets are full byte addresses
package intc_pkg;

   localparam logic [31:0] OFS_NVEC  = 32'hFFFFF100;
   localparam logic [31:0] OFS_FVEC  = 32'hFFFFF104;
   localparam logic [31:0] OFS_PEND  = 32'hFFFFF10C;
   localparam logic [31:0] OFS_ENAB  = 32'hFFFFF110;
   localparam logic [31:0] OFS_LINE  = 32'hFFFFF114;
   localparam logic [31:0] OFS_ENCMD = 32'hFFFFF120;
   localparam logic [31:0] OFS_DISCMD = 32'hFFFFF124;
   localparam logic [31:0] OFS_CLRCMD = 32'hFFFFF128;
   localparam logic [31:0] OFS_SETCMD = 32'hFFFFF12C;
   localparam logic [31:0] OFS_EOI   = 32'hFFFFF130;
   localparam logic [31:0] OFS_SPU   = 32'hFFFFF134;
   localparam logic [31:0] OFS_DBG   = 32'hFFFFF138;
   localparam logic [31:0] OFS_FFEN  = 32'hFFFFF140;
   localparam logic [31:0] OFS_FFDIS = 32'hFFFFF144;
   localparam logic [31:0] OFS_FFST  = 32'hFFFFF148;

   localparam int          DBG_PROTECTION_MODE_BIT_BIT  = 0;
   localparam int          DBG_GLOBAL_LINE_MASK_BIT  = 1;
   localparam int          LINE_FAST_BIT = 0;
   localparam int          LINE_NORM_BIT = 1;
   localparam int          FAST_SRC_BIT  = 0;
   localparam logic [31:0] FF_MASK       = 32'hFFFFFFFE;
   localparam logic [31:0] RST_WORD      = 32'h00000000;
   localparam logic [4:0]  RST_ID        = 5'h00;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
   } dphase_s;

   typedef struct packed {
      logic [31:0] enabled;
      logic [31:0] pending;
      logic [31:0] ffs;
      logic [31:0] spu;
      logic        protection_mode_bit;
      logic        global_line_mask;
      logic        in_service;
      logic [4:0]  cur_id;
      logic        fast_n;
      logic        norm_n;
      logic [31:0] rdata;
      logic        ready;
      dphase_s     dp;
   } state_s;

endpackage

// [core/intc_cmd_status.sv]
// Purpose: Command and status registers of a vectored interrupt unit
// Assumes: Sources are level inputs on hclk; AHB-Lite single slave
// Notes:   Reads take one wait state; writes take none
// Contract
// - Pending register: bit 0 fast, bit 1 system, bits 2-31 peripherals
// - Enabled status reads 1 for each enabled source, same layout
// - Line status bit 0 reads 1 while fast request line is active
// - Line status bit 1 reads 1 while normal request line is active
// - Enable command: ones enable sources, zeros leave them alone
// - Disable command: ones disable sources, zeros leave them alone
// - Clear command: ones clear the pending state of sources
// - Set command: ones force sources pending, zeros do nothing
// - Any write to end-of-service ends the current treatment
// - Spurious vector holds 32 bits, returned by spurious vector reads
// - Debug bit 0 selects protection mode, readable and writable
// - Debug bit 1 set holds both request lines inactive
// - Fast force enable: ones enable forcing for bits 1-31, bit 0 none
// - Fast force disable clears forcing; status shows enabled sources
// - Normal vector read with nothing current returns spurious vector
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module intc_cmd_status
(
   input  wire logic        hclk,                  // System clock
   input  wire logic        hresetn,               // Async reset, active low
   input  wire logic        hsel,                  // Slave select
   input  wire logic [31:0] haddr,                 // Byte address
   input  wire logic [1:0]  htrans,                // Transfer type
   input  wire logic        hwrite,                // Write when high
   input  wire logic [2:0]  hsize,                 // Transfer size
   input  wire logic [31:0] hwdata,                // Write data
   input  wire logic        hready,                // Bus ready
   input  wire logic [31:0] src_level,             // Source requests, high active
   output logic      [31:0] hrdata,                // Read data
   output logic             hreadyout,             // Slave ready
   output logic             hresp,                 // Always OKAY
   output logic             fast_request_line_n,   // Fast request, low active
   output logic             normal_request_line_n  // Normal request, low active
);

   intc_pkg::state_s s;
   intc_pkg::state_s next_s;

   // Lowest-numbered set bit of a request vector
   function automatic logic [4:0] lowest_id(input logic [31:0] v);
      logic [4:0] id;
      id = 5'h00;
      for (int i = 31; i >= 0; i--)
      begin
         if (v[i])
         begin
            id = 5'(i);
         end
      end
      return id;
   endfunction

   // Read data phase aimed at one register
   function automatic logic rd_hit(input intc_pkg::dphase_s dp, input logic [31:0] a);
      return dp.valid && !dp.write && dp.addr == a;
   endfunction

   // Write data phase aimed at one register
   function automatic logic wr_hit(input intc_pkg::dphase_s dp, input logic [31:0] a);
      return dp.valid && dp.write && dp.addr == a;
   endfunction

   // Vector word for a source number
   function automatic logic [31:0] vec_word(input logic [4:0] id);
      return {27'h0, id};
   endfunction

   logic        wr;
   logic        addr_ok;
   logic [31:0] masked;
   logic [31:0] norm_req_v;
   logic        norm_req;
   logic        fast_req;
   logic        line_fast;
   logic        line_norm;
   logic [31:0] enc;
   logic [31:0] dis;
   logic [31:0] clr;
   logic [31:0] setv;
   logic [31:0] rd_val;
   logic        rd_nvec;

   assign wr      = s.dp.valid && s.dp.write;
   assign addr_ok = hsel && hready && htrans == intc_pkg::HTRANS_NONSEQ;
   assign masked  = s.pending & s.enabled;
   assign norm_req_v = masked & ~s.ffs & intc_pkg::FF_MASK;
   assign norm_req = |norm_req_v && !s.in_service;
   assign fast_req = masked[intc_pkg::FAST_SRC_BIT]
                     || |(masked & s.ffs & intc_pkg::FF_MASK);
   assign line_fast = fast_req && !s.global_line_mask;
   assign line_norm = norm_req && !s.global_line_mask;

   always_comb
   begin
      next_s = s;
      enc  = (wr && s.dp.addr == intc_pkg::OFS_ENCMD)  ? hwdata : intc_pkg::RST_WORD;
      dis  = (wr && s.dp.addr == intc_pkg::OFS_DISCMD) ? hwdata : intc_pkg::RST_WORD;
      clr  = (wr && s.dp.addr == intc_pkg::OFS_CLRCMD) ? hwdata : intc_pkg::RST_WORD;
      setv = (wr && s.dp.addr == intc_pkg::OFS_SETCMD) ? hwdata : intc_pkg::RST_WORD;
      rd_val  = intc_pkg::RST_WORD;
      rd_nvec = 1'b0;

      next_s.enabled = (s.enabled | enc) & ~dis;
      // Source level and set command win over a clear
      next_s.pending = (s.pending & ~clr) | src_level | setv;

      if (wr)
      begin
         unique case (s.dp.addr)
            intc_pkg::OFS_EOI:
            begin
               next_s.in_service = 1'b0;
            end
            intc_pkg::OFS_SPU:
            begin
               next_s.spu = hwdata;
            end
            intc_pkg::OFS_DBG:
            begin
               next_s.protection_mode_bit = hwdata[intc_pkg::DBG_PROTECTION_MODE_BIT_BIT];
               next_s.global_line_mask = hwdata[intc_pkg::DBG_GLOBAL_LINE_MASK_BIT];
            end
            intc_pkg::OFS_FFEN:
            begin
               next_s.ffs = s.ffs | (hwdata & intc_pkg::FF_MASK);
            end
            intc_pkg::OFS_FFDIS:
            begin
               next_s.ffs = s.ffs & ~hwdata;
            end
            intc_pkg::OFS_NVEC:
            begin
               // In protection mode the debugger's write commits the entry
               rd_nvec = s.protection_mode_bit;
            end
            default:
            begin
               next_s.ffs = s.ffs;
            end
         endcase
      end

      if (s.dp.valid && !s.dp.write)
      begin
         unique case (s.dp.addr)
            intc_pkg::OFS_NVEC:
            begin
               rd_val  = norm_req ? vec_word(lowest_id(norm_req_v))
                                  : s.spu;
               rd_nvec = !s.protection_mode_bit;
            end
            intc_pkg::OFS_FVEC:
            begin
               rd_val = fast_req ? vec_word(lowest_id(masked & (s.ffs | 32'h00000001)))
                                 : s.spu;
            end
            intc_pkg::OFS_PEND:   rd_val = s.pending;
            intc_pkg::OFS_ENAB:   rd_val = s.enabled;
            intc_pkg::OFS_LINE:
            begin
               rd_val[intc_pkg::LINE_FAST_BIT] = !s.fast_n;
               rd_val[intc_pkg::LINE_NORM_BIT] = !s.norm_n;
            end
            intc_pkg::OFS_SPU:    rd_val = s.spu;
            intc_pkg::OFS_DBG:
            begin
               rd_val[intc_pkg::DBG_PROTECTION_MODE_BIT_BIT] = s.protection_mode_bit;
               rd_val[intc_pkg::DBG_GLOBAL_LINE_MASK_BIT] = s.global_line_mask;
            end
            intc_pkg::OFS_FFST:   rd_val = s.ffs;
            default:              rd_val = intc_pkg::RST_WORD;
         endcase
      end

      // Reading the vector outside protection mode, or writing it in protection mode, while a source is ready starts its treatment
      if (rd_nvec && norm_req)
      begin
         next_s.in_service = 1'b1;
         next_s.cur_id     = lowest_id(norm_req_v);
      end

      next_s.fast_n = !line_fast;
      next_s.norm_n = !line_norm;

      // Reads take one wait state so read data comes from a flop
      next_s.rdata    = rd_val;
      next_s.ready    = 1'b1;
      next_s.dp.valid = 1'b0;
      if (addr_ok)
      begin
         next_s.dp.valid = 1'b1;
         next_s.dp.write = hwrite;
         next_s.dp.addr  = haddr;
         next_s.ready    = hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s.enabled    <= intc_pkg::RST_WORD;
         s.pending    <= intc_pkg::RST_WORD;
         s.ffs        <= intc_pkg::RST_WORD;
         s.spu        <= intc_pkg::RST_WORD;
         s.protection_mode_bit       <= 1'b0;
         s.global_line_mask       <= 1'b0;
         s.in_service <= 1'b0;
         s.cur_id     <= intc_pkg::RST_ID;
         s.fast_n     <= 1'b1;
         s.norm_n     <= 1'b1;
         s.rdata      <= intc_pkg::RST_WORD;
         s.ready      <= 1'b1;
         s.dp.valid   <= 1'b0;
         s.dp.write   <= 1'b0;
         s.dp.addr    <= intc_pkg::RST_WORD;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign hrdata                = s.rdata;
   assign hreadyout             = s.ready;
   assign hresp                 = 1'b0;
   assign fast_request_line_n   = s.fast_n;
   assign normal_request_line_n = s.norm_n;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_set_forces_pend: assert property (
      (wr && s.dp.addr == intc_pkg::OFS_SETCMD)
      |=> ((s.pending & $past(hwdata)) == $past(hwdata)))
      else $error("Set command did not make sources pending");

   a_clear_drops_pend: assert property (
      (wr && s.dp.addr == intc_pkg::OFS_CLRCMD && (hwdata & src_level) == 32'h0)
      |=> ((s.pending & $past(hwdata)) == 32'h0))
      else $error("Clear command left sources pending");

   a_enable_cmd: assert property (
      (wr && s.dp.addr == intc_pkg::OFS_ENCMD)
      |=> (s.enabled == ($past(s.enabled) | $past(hwdata))))
      else $error("Enable command result wrong");

   a_disable_cmd: assert property (
      (wr && s.dp.addr == intc_pkg::OFS_DISCMD)
      |=> (s.enabled == ($past(s.enabled) & ~$past(hwdata))))
      else $error("Disable command result wrong");

   a_global_line_mask_holds_lines: assert property (
      s.global_line_mask ##1 s.global_line_mask |-> fast_request_line_n && normal_request_line_n)
      else $error("Request line active under general mask");

   a_eoi_ends_service: assert property (
      (wr && s.dp.addr == intc_pkg::OFS_EOI) |=> !s.in_service)
      else $error("End of service did not end treatment");

   a_spurious_vec: assert property (
      (s.dp.valid && !s.dp.write && s.dp.addr == intc_pkg::OFS_NVEC && !norm_req)
      |=> hreadyout && hrdata == $past(s.spu))
      else $error("Spurious vector not returned");

   a_line_status: assert property (
      (s.dp.valid && !s.dp.write && s.dp.addr == intc_pkg::OFS_LINE)
      |=> hrdata[1:0] == {!$past(normal_request_line_n), !$past(fast_request_line_n)})
      else $error("Line status mismatch");

   a_ffen_bit0_dead: assert property (
      s.ffs[intc_pkg::FAST_SRC_BIT] == 1'b0)
      else $error("Fast force bit 0 became set");

   a_wo_reads_zero: assert property (
      (s.dp.valid && !s.dp.write && s.dp.addr == intc_pkg::OFS_ENCMD)
      |=> hrdata == 32'h0)
      else $error("Write-only register read nonzero");

   // Status readback
   a_pend_read: assert property (
      rd_hit(s.dp, intc_pkg::OFS_PEND) |=> hrdata == $past(s.pending))
      else $error("Pending status read wrong");

   a_enab_read: assert property (
      rd_hit(s.dp, intc_pkg::OFS_ENAB) |=> hrdata == $past(s.enabled))
      else $error("Enabled status read wrong");

   a_ffst_read: assert property (
      rd_hit(s.dp, intc_pkg::OFS_FFST) |=> hrdata == $past(s.ffs))
      else $error("Fast force status read wrong");

   a_dbg_readback: assert property (
      rd_hit(s.dp, intc_pkg::OFS_DBG)
      |=> hrdata == {30'h0, $past(s.global_line_mask), $past(s.protection_mode_bit)})
      else $error("Debug control read wrong");

   a_wo_others_zero: assert property (
      (rd_hit(s.dp, intc_pkg::OFS_DISCMD) || rd_hit(s.dp, intc_pkg::OFS_CLRCMD)
       || rd_hit(s.dp, intc_pkg::OFS_SETCMD) || rd_hit(s.dp, intc_pkg::OFS_EOI)
       || rd_hit(s.dp, intc_pkg::OFS_FFEN) || rd_hit(s.dp, intc_pkg::OFS_FFDIS))
      |=> hrdata == 32'h0)
      else $error("Write-only command read nonzero");

   a_fast_spurious: assert property (
      (rd_hit(s.dp, intc_pkg::OFS_FVEC) && !fast_req) |=> hrdata == $past(s.spu))
      else $error("Fast spurious vector not returned");

   a_vector_claims: assert property (
      (rd_hit(s.dp, intc_pkg::OFS_NVEC) && norm_req && !s.protection_mode_bit)
      |=> s.in_service && hrdata == vec_word(s.cur_id))
      else $error("Vector read did not claim the source");

   // Command effects
   a_src_latches: assert property (
      (src_level != 32'h0) |=> ((s.pending & $past(src_level)) == $past(src_level)))
      else $error("Active source not latched pending");

   a_set_zero_noop: assert property (
      (wr_hit(s.dp, intc_pkg::OFS_SETCMD) && src_level == 32'h0)
      |=> ((s.pending & ~$past(hwdata)) == ($past(s.pending) & ~$past(hwdata))))
      else $error("Set command touched a zero bit");

   a_spu_write: assert property (
      wr_hit(s.dp, intc_pkg::OFS_SPU) |=> s.spu == $past(hwdata))
      else $error("Spurious vector write lost");

   a_protection_mode_bit_write: assert property (
      wr_hit(s.dp, intc_pkg::OFS_DBG)
      |=> s.protection_mode_bit == $past(hwdata[intc_pkg::DBG_PROTECTION_MODE_BIT_BIT]))
      else $error("Protection bit write lost");

   a_global_line_mask_write: assert property (
      wr_hit(s.dp, intc_pkg::OFS_DBG)
      |=> s.global_line_mask == $past(hwdata[intc_pkg::DBG_GLOBAL_LINE_MASK_BIT]))
      else $error("General mask write lost");

   a_ffen_sets: assert property (
      wr_hit(s.dp, intc_pkg::OFS_FFEN)
      |=> ((s.ffs & $past(hwdata) & intc_pkg::FF_MASK) == ($past(hwdata) & intc_pkg::FF_MASK)))
      else $error("Fast force enable lost");

   a_ffdis_clears: assert property (
      wr_hit(s.dp, intc_pkg::OFS_FFDIS) |=> ((s.ffs & $past(hwdata)) == 32'h0))
      else $error("Fast force disable left sources forced");

   // Request lines
   a_fast_src_line: assert property (
      (s.pending[intc_pkg::FAST_SRC_BIT] && s.enabled[intc_pkg::FAST_SRC_BIT] && !s.global_line_mask)
      |=> !fast_request_line_n)
      else $error("Fast source did not drive fast line");

   a_norm_line_on: assert property (
      (norm_req && !s.global_line_mask) |=> !normal_request_line_n)
      else $error("Normal request did not drive normal line");

   a_mask_blocks_lines: assert property (
      (s.enabled == 32'h0) ##1 (s.enabled == 32'h0)
      |-> fast_request_line_n && normal_request_line_n)
      else $error("Request line active with all sources disabled");

   c_fast_line: cover property (!fast_request_line_n);
   c_vector_taken: cover property (rd_nvec && norm_req);
   c_eoi_after_service: cover property (s.in_service ##[1:20] !s.in_service);
   c_spurious_read: cover property (rd_hit(s.dp, intc_pkg::OFS_NVEC) && !norm_req);
   c_masked_request: cover property (s.global_line_mask && (fast_req || norm_req));

endmodule

// [tb/core_model.sv]
// Purpose: Processor core side, samples the two request lines
// Assumes: Lines are low active and synchronous to hclk
// Notes:   Flags show which request the core would take
`timescale 1ns/1ps
module core_model
(
   input  wire logic hclk,        // System clock
   input  wire logic hresetn,     // Async reset, active low
   input  wire logic fast_line_n, // Fast request in
   input  wire logic norm_line_n, // Normal request in
   output logic      fast_taken,  // Fast request seen
   output logic      norm_taken   // Normal request seen
);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fast_taken <= 1'h0;
         norm_taken <= 1'h0;
      end
      else
      begin
         fast_taken <= !fast_line_n;
         norm_taken <= !norm_line_n;
      end
   end
endmodule

// [tb/interrupt_command_status_regs_tb_top.sv]
// Purpose: Self-checking bench for the command and status registers
// Assumes: One AHB-Lite slave, hready fed back from hreadyout
// Notes:   Scenarios run in order; each leaves no source pending
`timescale 1ns/1ps
module interrupt_command_status_regs_tb_top;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] src_level;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        fast_n;
   logic        norm_n;
   logic        fast_taken;
   logic        norm_taken;
   int          miscompares;
   int          total_checks;

   intc_cmd_status u_intc_cmd_status (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .src_level(src_level), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .fast_request_line_n(fast_n), .normal_request_line_n(norm_n));
   core_model u_core_model (.hclk(hclk), .hresetn(hresetn), .fast_line_n(fast_n),
      .norm_line_n(norm_n), .fast_taken(fast_taken), .norm_taken(norm_taken));

   initial
   begin
      hclk = 1'h0;
      forever #10 hclk = ~hclk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd);
      htrans <= intc_pkg::HTRANS_NONSEQ;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] rd;
      xfer(a, 1'h1, d, rd);
   endtask

   task automatic rc(input string name, input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      xfer(a, 1'h0, 32'h00000000, rd);
      chk(name, rd, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic s_reset();
      rc("pending", intc_pkg::OFS_PEND, 32'h00000000);
      rc("enabled", intc_pkg::OFS_ENAB, 32'h00000000);
      rc("lines", intc_pkg::OFS_LINE, 32'h00000000);
      rc("debug", intc_pkg::OFS_DBG, 32'h00000000);
      rc("enable cmd", intc_pkg::OFS_ENCMD, 32'h00000000);
      chk("response", {31'h0, hresp}, 32'h00000000);
      rc("unmapped", 32'hFFFFF118, 32'h00000000);
   endtask

   task automatic s_mask();
      wr(intc_pkg::OFS_ENCMD, 32'h000000F0);
      wr(intc_pkg::OFS_ENCMD, 32'h00000F00);
      rc("enabled", intc_pkg::OFS_ENAB, 32'h00000FF0);
      wr(intc_pkg::OFS_DISCMD, 32'h00000030);
      rc("enabled", intc_pkg::OFS_ENAB, 32'h00000FC0);
      wr(intc_pkg::OFS_DISCMD, 32'hFFFFFFFF);
      rc("disable cmd", intc_pkg::OFS_DISCMD, 32'h00000000);
      rc("enabled", intc_pkg::OFS_ENAB, 32'h00000000);
   endtask

   task automatic s_pend();
      wr(intc_pkg::OFS_SETCMD, 32'h00000005);
      wr(intc_pkg::OFS_SETCMD, 32'h00000000);
      rc("pending", intc_pkg::OFS_PEND, 32'h00000005);
      wr(intc_pkg::OFS_CLRCMD, 32'h00000001);
      rc("pending", intc_pkg::OFS_PEND, 32'h00000004);
      src_level <= 32'h00000200;
      idle(2);
      rc("pending", intc_pkg::OFS_PEND, 32'h00000204);
      src_level <= 32'h00000000;
      idle(2);
      wr(intc_pkg::OFS_CLRCMD, 32'hFFFFFFFF);
      rc("pending", intc_pkg::OFS_PEND, 32'h00000000);
   endtask

   task automatic s_lines();
      wr(intc_pkg::OFS_SPU, 32'hCAFE0001);
      rc("normal vec", intc_pkg::OFS_NVEC, 32'hCAFE0001);
      rc("fast vec", intc_pkg::OFS_FVEC, 32'hCAFE0001);
      wr(intc_pkg::OFS_SETCMD, 32'h00000004);
      wr(intc_pkg::OFS_ENCMD, 32'h00000004);
      idle(3);
      chk("normal line", {31'h0, norm_n}, 32'h00000000);
      rc("lines", intc_pkg::OFS_LINE, 32'h00000002);
      rc("normal vec", intc_pkg::OFS_NVEC, 32'h00000002);
      idle(3);
      chk("core normal", {31'h0, norm_taken}, 32'h00000000);
      wr(intc_pkg::OFS_EOI, 32'h12345678);
      idle(3);
      chk("core normal", {31'h0, norm_taken}, 32'h00000001);
      wr(intc_pkg::OFS_SETCMD, 32'h00000001);
      wr(intc_pkg::OFS_ENCMD, 32'h00000001);
      idle(3);
      rc("lines", intc_pkg::OFS_LINE, 32'h00000003);
      chk("core fast", {31'h0, fast_taken}, 32'h00000001);
      wr(intc_pkg::OFS_DBG, 32'h00000002);
      idle(3);
      rc("lines", intc_pkg::OFS_LINE, 32'h00000000);
      chk("pins", {30'h0, fast_n, norm_n}, 32'h00000003);
      wr(intc_pkg::OFS_DBG, 32'h00000001);
      rc("debug", intc_pkg::OFS_DBG, 32'h00000001);
      wr(intc_pkg::OFS_DISCMD, 32'hFFFFFFFF);
      wr(intc_pkg::OFS_CLRCMD, 32'hFFFFFFFF);
   endtask

   task automatic s_force();
      wr(intc_pkg::OFS_FFEN, 32'hFFFFFFFF);
      rc("force st", intc_pkg::OFS_FFST, intc_pkg::FF_MASK);
      wr(intc_pkg::OFS_FFDIS, 32'h00000002);
      rc("force st", intc_pkg::OFS_FFST, 32'hFFFFFFFC);
   endtask

   initial
   begin
      repeat (5000) @(posedge hclk);
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      hresetn = 1'h0;
      hsel = 1'h1;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      src_level = 32'h00000000;
      miscompares = 0;
      total_checks = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      s_reset();
      s_mask();
      s_pend();
      s_lines();
      s_force();
      report_and_stop();
   end
endmodule
